// ---- rtl/iscs_top.sv ----
// Serial slave configuration and status/control register block with its bus-side sequencer.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module iscs_top
    import iscs_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       reset_n_i,
    // Register port
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // Master-side start or restart generate write
    input  wire logic       mstart_wr_i,
    // Byte to send and last byte received
    input  wire logic [7:0] tx_data_i,
    output logic      [7:0] rx_data_o,
    // Interrupt
    output logic            irq_o,
    // Pin pair A
    input  wire logic       scl_a_i,
    output logic            scl_a_o,
    output logic            scl_a_oe_o,
    input  wire logic       sda_a_i,
    output logic            sda_a_o,
    output logic            sda_a_oe_o,
    // Pin pair B
    input  wire logic       scl_b_i,
    output logic            scl_b_o,
    output logic            scl_b_oe_o,
    input  wire logic       sda_b_i,
    output logic            sda_b_o,
    output logic            sda_b_oe_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]       cfg;
        logic [7:0]       scr;
        logic [7:0]       mask;
        logic [7:0]       rdata;
        logic             irq;
        iscs_st_t         st;
        logic [3:0]       bitcnt;
        logic             first;
        logic             hold_tx;
        logic             pend;
        logic [CNT_W-1:0] cnt;
        logic [7:0]       sh;
        logic [7:0]       rx;
        logic             scl_oe;
        logic             sda_oe;
        logic [1:0]       pin_scl_oe;
        logic [1:0]       pin_sda_oe;
        logic [2:0]       scl_s;
        logic [2:0]       sda_s;
        logic             scl_f;
        logic             sda_f;
    } iscs_state_t;

    iscs_state_t r;
    iscs_state_t n;
    logic [1:0]  rst_sync_r;
    logic        rst_n;
    logic        scl_nf;
    logic        sda_nf;
    logic        rise;
    logic        fall;
    logic        start_det;
    logic        stop_det;
    logic        en;
    logic [7:0]  irq_gate;

    // Minimum SCL low time while stretching, chosen by the speed field.
    function automatic logic [CNT_W-1:0] tlow(input logic [1:0] spd);
        case (spd)
            SPD_400K: return TLOW_400K_CYC;
            SPD_50K:  return TLOW_50K_CYC;
            default:  return TLOW_100K_CYC;
        endcase
    endfunction : tlow

    function automatic logic tx_bit(input logic [7:0] d, input logic [3:0] done);
        return d[3'(MSB_IDX - done)];
    endfunction : tx_bit

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // ----------------------------------------------------------------
    // Pin filtering and bus conditions
    // ----------------------------------------------------------------
    // A level is accepted only once the second and third stages agree.
    assign scl_nf    = (r.scl_s[1] == r.scl_s[2]) ? r.scl_s[2] : r.scl_f;
    assign sda_nf    = (r.sda_s[1] == r.sda_s[2]) ? r.sda_s[2] : r.sda_f;
    assign rise      = !r.scl_f && scl_nf;
    assign fall      = r.scl_f && !scl_nf;
    assign start_det = r.scl_f && scl_nf && r.sda_f && !sda_nf;
    assign stop_det  = r.scl_f && scl_nf && !r.sda_f && sda_nf;
    assign en        = r.cfg[CFG_EN];

    always_comb
    begin
        irq_gate              = 8'hFF;
        irq_gate[SCR_STOP]    = r.cfg[CFG_HALT_CONDITION_IRQ_ENABLE];
        irq_gate[SCR_BERR]    = r.cfg[CFG_BERR_IE];
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        n       = r;
        n.scl_s = {r.scl_s[1:0], r.cfg[CFG_PIN] ? scl_b_i : scl_a_i};
        n.sda_s = {r.sda_s[1:0], r.cfg[CFG_PIN] ? sda_b_i : sda_a_i};
        n.scl_f = scl_nf;
        n.sda_f = sda_nf;
        n.rdata = 8'h00;

        if (rd_i)
        begin
            case (addr_i)
                CFG_ADDR:  n.rdata = r.cfg;
                SCR_ADDR:  n.rdata = r.scr;
                MASK_ADDR: n.rdata = r.mask;
                default:   n.rdata = 8'h00;
            endcase
        end

        if (wr_i)
        begin
            case (addr_i)
                CFG_ADDR:  n.cfg = wdata_i & CFG_WMASK;
                MASK_ADDR: n.mask = wdata_i;
                SCR_ADDR:
                begin
                    // Zero clears a flag, one leaves it; reserved bit 6 is never stored.
                    n.scr = (r.scr & wdata_i & SCR_RC_MASK)
                          | (wdata_i & SCR_RW_MASK)
                          | (r.scr & SCR_RO_MASK);
                    n.pend = (r.st == ST_HOLD);
                end
                default: ;
            endcase
        end

        if (mstart_wr_i)
        begin
            n.scr[SCR_TX]  = 1'b0;
            n.scr[SCR_LRB] = 1'b0;
            n.scr[SCR_BC]  = 1'b0;
        end

        // Bus events are applied after the register write so a set beats a clear.
        // A legal start or stop follows the first clock rise of a byte, so only a later one is misplaced.
        if (start_det)
        begin
            if (r.st != ST_IDLE && r.bitcnt > 4'h1)
                n.scr[SCR_BERR] = 1'b1;
            n.scr[SCR_TX]  = 1'b0;
            n.scr[SCR_LRB] = 1'b0;
            n.scr[SCR_BC]  = 1'b0;
            n.bitcnt = 4'h0;
            n.first  = 1'b1;
            n.st     = ST_BITS;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
        end
        else if (stop_det)
        begin
            if (r.st == ST_BITS && r.bitcnt > 4'h1)
                n.scr[SCR_BERR] = 1'b1;
            n.scr[SCR_STOP] = 1'b1;
            n.st     = ST_IDLE;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
        end
        else
        begin
            // Flags change only on the events below and hold otherwise.
            case (r.st)
                ST_BITS:
                begin
                    if (rise)
                    begin
                        n.sh     = {r.sh[6:0], sda_nf};
                        n.bitcnt = r.bitcnt + 4'h1;
                    end
                    else if (fall && r.bitcnt == BYTE_BITS)
                    begin
                        if (r.scr[SCR_TX])
                        begin
                            n.sda_oe  = 1'b0;
                            n.hold_tx = 1'b1;
                            n.st      = ST_ACK;
                        end
                        else
                        begin
                            n.scr[SCR_BC]     = 1'b1;
                            n.scr[SCR_ACK]    = 1'b0;
                            n.scr[SCR_ADDR_B] = n.scr[SCR_ADDR_B] | r.first;
                            n.first   = 1'b0;
                            n.rx      = r.sh;
                            n.hold_tx = 1'b0;
                            n.scl_oe  = 1'b1;
                            n.cnt     = tlow(r.cfg[CFG_SPD_HI:CFG_SPD_LO]);
                            n.pend    = 1'b0;
                            n.st      = ST_HOLD;
                        end
                    end
                    else if (fall && r.scr[SCR_TX])
                        n.sda_oe = !tx_bit(tx_data_i, r.bitcnt);
                end
                ST_ACK:
                begin
                    if (rise && r.hold_tx)
                    begin
                        n.scr[SCR_LRB] = sda_nf;
                        n.scr[SCR_BC]  = 1'b1;
                        n.scr[SCR_ACK] = 1'b0;
                    end
                    else if (fall && r.hold_tx)
                    begin
                        n.scl_oe = 1'b1;
                        n.cnt    = tlow(r.cfg[CFG_SPD_HI:CFG_SPD_LO]);
                        n.pend   = 1'b0;
                        n.st     = ST_HOLD;
                    end
                    else if (fall)
                    begin
                        n.bitcnt = 4'h0;
                        n.sda_oe = r.scr[SCR_TX] && !tx_bit(tx_data_i, 4'h0);
                        n.st     = ST_BITS;
                    end
                end
                ST_HOLD:
                begin
                    if (r.cnt != '0)
                        n.cnt = r.cnt - CNT_W'(1);
                    else if (r.pend)
                    begin
                        n.scl_oe = 1'b0;
                        n.pend   = 1'b0;
                        if (r.hold_tx)
                        begin
                            n.bitcnt = 4'h0;
                            n.sda_oe = r.scr[SCR_TX] && !tx_bit(tx_data_i, 4'h0);
                            n.st     = ST_BITS;
                        end
                        else
                        begin
                            n.sda_oe = r.scr[SCR_ACK];
                            n.st     = ST_ACK;
                        end
                    end
                end
                default: n.st = ST_IDLE;
            endcase
        end

        if (!en)
        begin
            n.scr    = SCR_RST;
            n.st     = ST_IDLE;
            n.first  = 1'b0;
            n.pend   = 1'b0;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
        end

        n.pin_scl_oe = r.cfg[CFG_PIN] ? {n.scl_oe, 1'b0} : {1'b0, n.scl_oe};
        n.pin_sda_oe = r.cfg[CFG_PIN] ? {n.sda_oe, 1'b0} : {1'b0, n.sda_oe};
        n.irq        = |(n.scr & r.mask & irq_gate & SCR_RC_MASK);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r       <= '0;
            r.cfg   <= CFG_RST;
            r.scr   <= SCR_RST;
            r.mask  <= MASK_RST;
            r.st    <= ST_IDLE;
            r.scl_s <= 3'b111;
            r.sda_s <= 3'b111;
            r.scl_f <= 1'b1;
            r.sda_f <= 1'b1;
        end
        else
            r <= n;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Open-drain pins only ever pull low, so the data outputs are a fixed zero.
    assign rdata_o    = r.rdata;
    assign rx_data_o  = r.rx;
    assign irq_o      = r.irq;
    assign scl_a_o    = 1'b0;
    assign sda_a_o    = 1'b0;
    assign scl_b_o    = 1'b0;
    assign sda_b_o    = 1'b0;
    assign scl_a_oe_o = r.pin_scl_oe[0];
    assign scl_b_oe_o = r.pin_scl_oe[1];
    assign sda_a_oe_o = r.pin_sda_oe[0];
    assign sda_b_oe_o = r.pin_sda_oe[1];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n);

    property p_disabled_clear;
        !n.cfg[CFG_EN] && !en |=> r.scr == SCR_RST ##1 r.scr == SCR_RST || r.cfg[CFG_EN];
    endproperty
    a_disabled_clear: assert property (p_disabled_clear) else $error("status bits not held while disabled");

    property p_stop_irq;
        en && stop_det && r.cfg[CFG_HALT_CONDITION_IRQ_ENABLE] && r.mask[SCR_STOP] |=> irq_o && r.scr[SCR_STOP];
    endproperty
    a_stop_irq: assert property (p_stop_irq) else $error("stop did not raise interrupt");

    property p_stop_masked;
        !r.cfg[CFG_HALT_CONDITION_IRQ_ENABLE] && (r.scr & r.mask & SCR_RC_MASK) == (8'h01 << SCR_STOP) ##1
            $stable(r.cfg) && $stable(r.mask) && $stable(r.scr) |-> !irq_o;
    endproperty
    a_stop_masked: assert property (p_stop_masked) else $error("stop interrupt while disabled");

    property p_berr_irq;
        en && start_det && r.st != ST_IDLE && r.bitcnt > 4'h1 && r.cfg[CFG_BERR_IE] && r.mask[SCR_BERR]
            |=> r.scr[SCR_BERR] && irq_o;
    endproperty
    a_berr_irq: assert property (p_berr_irq) else $error("misplaced start missed");

    property p_berr_sticky;
        r.scr[SCR_BERR] && en && !(wr_i && addr_i == SCR_ADDR && !wdata_i[SCR_BERR]) |=> r.scr[SCR_BERR];
    endproperty
    a_berr_sticky: assert property (p_berr_sticky) else $error("bus error cleared by hardware");

    property p_ack_clear;
        !r.scr[SCR_BC] ##1 r.scr[SCR_BC] && !$past(wr_i) |-> !r.scr[SCR_ACK];
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("ack not cleared on byte complete");

    property p_start_clears;
        en && start_det |=> !r.scr[SCR_TX] && !r.scr[SCR_LRB] && !r.scr[SCR_BC] && r.st == ST_BITS;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start did not clear direction flags");

    property p_addr_first;
        en && !start_det && !stop_det && r.st == ST_BITS && fall && r.bitcnt == BYTE_BITS
            && !r.scr[SCR_TX] && r.first |=> r.scr[SCR_ADDR_B] && r.scr[SCR_BC] && r.scl_oe;
    endproperty
    a_addr_first: assert property (p_addr_first) else $error("address byte not flagged");

    property p_lrb_capture;
        en && !start_det && !stop_det && r.st == ST_ACK && r.hold_tx && rise
            |=> r.scr[SCR_LRB] == $past(sda_nf) && r.scr[SCR_BC];
    endproperty
    a_lrb_capture: assert property (p_lrb_capture) else $error("ninth bit not captured");

    property p_stretch_min;
        $rose(r.scl_oe) && r.cfg[CFG_SPD_HI:CFG_SPD_LO] == SPD_400K && r.cfg[CFG_EN]
            |-> r.scl_oe [*8] ##0 r.cnt != '0;
    endproperty
    a_stretch_min: assert property (p_stretch_min) else $error("stretch shorter than low time");

    property p_pin_pair;
        r.cfg[CFG_PIN] |-> !scl_a_oe_o && !sda_a_oe_o ##1 1'b1;
    endproperty
    a_pin_pair: assert property (p_pin_pair) else $error("unselected pin pair driven");

endmodule : iscs_top
`default_nettype wire

// ---- rtl/iscs_pkg.sv ----
// Package with register map, field positions and timing of the serial slave config/status block.
package iscs_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] CFG_ADDR  = 8'hD6;
    localparam logic [7:0] SCR_ADDR  = 8'hD7;
    localparam logic [7:0] MASK_ADDR = 8'hDC;
    localparam logic [7:0] CFG_RST   = 8'h00;
    localparam logic [7:0] SCR_RST   = 8'h00;
    localparam logic [7:0] MASK_RST  = 8'h00;
    localparam logic [7:0] CFG_WMASK = 8'h7D;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CFG_EN      = 0;
    localparam int CFG_SPD_LO  = 2;
    localparam int CFG_SPD_HI  = 3;
    localparam int CFG_HALT_CONDITION_IRQ_ENABLE = 4;
    localparam int CFG_BERR_IE = 5;
    localparam int CFG_PIN     = 6;
    localparam int SCR_BC      = 0;
    localparam int SCR_LRB     = 1;
    localparam int SCR_TX      = 2;
    localparam int SCR_ADDR_B  = 3;
    localparam int SCR_ACK     = 4;
    localparam int SCR_STOP    = 5;
    localparam int SCR_BERR    = 7;
    localparam logic [7:0] SCR_RC_MASK = 8'hA9;
    localparam logic [7:0] SCR_RW_MASK = 8'h14;
    localparam logic [7:0] SCR_RO_MASK = 8'h02;

    // ----------------------------------------------------------------
    // Bus speed codes and timing
    // ----------------------------------------------------------------
    localparam logic [1:0] SPD_100K = 2'b00;
    localparam logic [1:0] SPD_400K = 2'b01;
    localparam logic [1:0] SPD_50K  = 2'b10;
    localparam int SYS_CLK_NS   = 5;
    localparam int TLOW_100K_NS = 4700;
    localparam int TLOW_400K_NS = 1300;
    localparam int TLOW_50K_NS  = 9400;
    localparam int CNT_W        = 11;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] MSB_IDX   = 4'h7;

    function automatic logic [CNT_W-1:0] ns2cyc(input int ns);
        return CNT_W'((ns + SYS_CLK_NS - 1) / SYS_CLK_NS);
    endfunction : ns2cyc

    localparam logic [CNT_W-1:0] TLOW_100K_CYC = ns2cyc(TLOW_100K_NS);
    localparam logic [CNT_W-1:0] TLOW_400K_CYC = ns2cyc(TLOW_400K_NS);
    localparam logic [CNT_W-1:0] TLOW_50K_CYC  = ns2cyc(TLOW_50K_NS);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BITS = 2'b01,
        ST_ACK  = 2'b11,
        ST_HOLD = 2'b10
    } iscs_st_t;

endpackage : iscs_pkg

// ---- sim/iscs_bus_master.sv ----
// Behavioural two-wire bus master that works the slave's pins through open-drain pull-low enables.
`timescale 1ns/100ps
`default_nettype none
module iscs_bus_master (
    // Wire levels
    input  wire logic scl_i,
    input  wire logic sda_i,
    // Pull-low enables
    output var logic  scl_oe_o,
    output var logic  sda_oe_o
);
    localparam int HALF = 80;

    initial
    begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end

    // The slave may stretch the clock, so the wait for the rise is bounded, never open ended.
    task automatic rise();
        scl_oe_o = 1'b0;
        for (int i = 0; i < 4000 && scl_i !== 1'b1; i++)
            #5;
    endtask : rise

    // A one leaves the data line released, so the same clock also reads what the slave drives.
    task automatic clock_bit(input logic drive, output logic seen);
        sda_oe_o = !drive;
        #(HALF/2);
        rise();
        #(HALF/2);
        seen = sda_i;
        #(HALF/2);
        scl_oe_o = 1'b1;
        #(HALF/2);
    endtask : clock_bit

    task automatic start();
        sda_oe_o = 1'b1;
        #HALF;
        scl_oe_o = 1'b1;
        #(HALF/2);
    endtask : start

    // Data is released while the clock is low, so the start falls while the clock is high.
    task automatic restart();
        sda_oe_o = 1'b0;
        #(HALF/2);
        rise();
        #(HALF/2);
        start();
    endtask : restart

    task automatic stop();
        sda_oe_o = 1'b1;
        #HALF;
        rise();
        #HALF;
        sda_oe_o = 1'b0;
        #HALF;
    endtask : stop
endmodule : iscs_bus_master
`default_nettype wire

// ---- sim/test_iscs_top.sv ----
// Self-checking bench of the serial slave config/status block driven by a behavioural bus master.
`timescale 1ns/100ps
`default_nettype none
module test_iscs_top
    import iscs_pkg::*;
();
    logic       clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, mstart = 1'b0, pair_b = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, tx_data = 8'h00, rdata, rx_data, got;
    logic       irq, m_scl_oe, m_sda_oe, bit_seen, scl_a_oe, sda_a_oe, scl_b_oe, sda_b_oe;
    int         error_cnt = 0, samples_checked = 0, cyc = 0, run_len = 0, stretch_len = 0;
    // The unselected pair is held idle high so only the chosen pins can carry traffic.
    wire logic scl_a = pair_b | !(m_scl_oe | scl_a_oe);
    wire logic sda_a = pair_b | !(m_sda_oe | sda_a_oe);
    wire logic scl_b = !pair_b | !(m_scl_oe | scl_b_oe);
    wire logic sda_b = !pair_b | !(m_sda_oe | sda_b_oe);

    always #2.5 clk = ~clk;

    iscs_top dut (.sys_clk_i(clk), .reset_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
        .rd_i(rd_s), .rdata_o(rdata), .mstart_wr_i(mstart), .tx_data_i(tx_data), .rx_data_o(rx_data),
        .irq_o(irq), .scl_a_i(scl_a), .scl_a_o(), .scl_a_oe_o(scl_a_oe), .sda_a_i(sda_a), .sda_a_o(),
        .sda_a_oe_o(sda_a_oe), .scl_b_i(scl_b), .scl_b_o(), .scl_b_oe_o(scl_b_oe), .sda_b_i(sda_b),
        .sda_b_o(), .sda_b_oe_o(sda_b_oe));

    iscs_bus_master m (.scl_i(pair_b ? scl_b : scl_a), .sda_i(pair_b ? sda_b : sda_a),
        .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));

    task automatic wrap_up();
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string what);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] e, input string what);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk(rdata & msk, e, what);
    endtask : rd_chk

    task automatic irq_chk(input logic e);
        repeat (2) @(negedge clk);
        chk({7'h0, irq}, {7'h0, e}, "irq");
    endtask : irq_chk

    // The slave must be pulling the clock low once a byte has ended.
    task automatic hold_chk();
        repeat (40) @(posedge clk);
        chk({7'h0, pair_b ? scl_b_oe : scl_a_oe}, 8'h01, "stretch");
    endtask : hold_chk

    // The last finished stretch must last the low time of its speed, with a few cycles of slack.
    task automatic len_chk(input int lo);
        samples_checked++;
        if (stretch_len < lo || stretch_len > lo + 8)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t stretch %0d cycles, low time %0d", $time, stretch_len, lo);
        end
    endtask : len_chk

    task automatic send(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++)
            m.clock_bit(b[7-i], bit_seen);
    endtask : send

    task automatic t_regs();
        rd_chk(CFG_ADDR, 8'hFF, 8'h00, "cfg reset");
        wr(SCR_ADDR, 8'h14);
        rd_chk(SCR_ADDR, 8'hFF, 8'h00, "scr disabled");
        wr(CFG_ADDR, 8'hFF);
        rd_chk(CFG_ADDR, 8'hFF, CFG_WMASK, "cfg rb");
        for (int s = 0; s < 4; s++)
        begin
            wr(CFG_ADDR, 8'(s << 2) | 8'h01);
            rd_chk(CFG_ADDR, 8'hFF, 8'(s << 2) | 8'h01, "speed");
        end
        rd_chk(8'hD8, 8'hFF, 8'h00, "unmapped");
        wr(SCR_ADDR, 8'h14);
        rd_chk(SCR_ADDR, 8'hFF, 8'h14, "scr rw");
        wr(SCR_ADDR, 8'h00);
        wr(MASK_ADDR, 8'hA9);
        rd_chk(MASK_ADDR, 8'hFF, 8'hA9, "mask");
    endtask : t_regs

    task automatic t_rx();
        wr(CFG_ADDR, 8'h11);
        m.start();
        send(8'hA5, 8);
        hold_chk();
        rd_chk(SCR_ADDR, 8'hFF, 8'h09, "addr byte");
        irq_chk(1'b1);
        chk(rx_data, 8'hA5, "rx addr");
        wr(SCR_ADDR, 8'h19);
        m.clock_bit(1'b1, bit_seen);
        chk({7'h0, bit_seen}, 8'h00, "ack out");
        len_chk(TLOW_100K_CYC);
        wr(CFG_ADDR, 8'h19);
        send(8'h3C, 8);
        hold_chk();
        rd_chk(SCR_ADDR, 8'hFF, 8'h09, "data byte");
        chk(rx_data, 8'h3C, "rx data");
        wr(SCR_ADDR, 8'h00);
        irq_chk(1'b0);
        m.clock_bit(1'b1, bit_seen);
        chk({7'h0, bit_seen}, 8'h01, "nak out");
        len_chk(TLOW_50K_CYC);
        m.stop();
        rd_chk(SCR_ADDR, 8'hFF, 8'h20, "stop");
        irq_chk(1'b1);
        wr(CFG_ADDR, 8'h01);
        irq_chk(1'b0);
        rd_chk(SCR_ADDR, 8'hFF, 8'h20, "stop kept");
        wr(SCR_ADDR, 8'h00);
    endtask : t_rx

    task automatic t_tx();
        wr(CFG_ADDR, 8'h05);
        @(posedge clk);
        tx_data <= 8'h96;
        wr(SCR_ADDR, 8'h04);
        m.start();
        send(8'hA7, 8);
        hold_chk();
        rd_chk(SCR_ADDR, 8'hFF, 8'h09, "start clears");
        wr(SCR_ADDR, 8'h14);
        m.clock_bit(1'b1, bit_seen);
        chk({7'h0, bit_seen}, 8'h00, "addr ack");
        len_chk(TLOW_400K_CYC);
        for (int i = 0; i < 8; i++)
        begin
            m.clock_bit(1'b1, bit_seen);
            got[7-i] = bit_seen;
        end
        chk(got, 8'h96, "tx byte");
        m.clock_bit(1'b1, bit_seen);
        hold_chk();
        rd_chk(SCR_ADDR, 8'hFF, 8'h07, "tx done");
        @(posedge clk);
        mstart <= 1'b1;
        @(posedge clk);
        mstart <= 1'b0;
        rd_chk(SCR_ADDR, 8'hFF, 8'h00, "mstart");
        wr(SCR_ADDR, 8'h00);
        m.stop();
        len_chk(TLOW_400K_CYC);
        wr(SCR_ADDR, 8'h00);
    endtask : t_tx

    task automatic t_berr();
        @(posedge clk);
        pair_b <= 1'b1;
        wr(CFG_ADDR, 8'h61);
        m.start();
        send(8'hA0, 3);
        m.restart();
        rd_chk(SCR_ADDR, 8'h80, 8'h80, "start err");
        irq_chk(1'b1);
        wr(SCR_ADDR, 8'h00);
        rd_chk(SCR_ADDR, 8'hFF, 8'h00, "err clr");
        irq_chk(1'b0);
        send(8'hA0, 3);
        m.stop();
        rd_chk(SCR_ADDR, 8'h80, 8'h80, "bus err");
        irq_chk(1'b1);
        rd_chk(SCR_ADDR, 8'h80, 8'h80, "bus err kept");
        wr(SCR_ADDR, 8'h00);
        rd_chk(SCR_ADDR, 8'hFF, 8'h00, "err clr 2");
        irq_chk(1'b0);
    endtask : t_berr

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (pair_b ? scl_b_oe : scl_a_oe)
            run_len <= run_len + 1;
        else if (run_len != 0)
        begin
            stretch_len <= run_len;
            run_len     <= 0;
        end
        if (cyc == 60000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_rx();
        t_tx();
        t_berr();
        wrap_up();
    end
endmodule : test_iscs_top
`default_nettype wire
